// [design/ssr_shift_register.v]
// Serial shift register core with pin synchronisers and a two-entry spill buffer.
`timescale 1ns/1ps
`include "ssr_regs.vh"

module ssr_shift_register
(
   input wire sys_clk,
   input wire rst_n,
   input wire shift_clock,
   input wire serial_in_a,
   input wire serial_in_b,
   input wire select,
   output reg buffered_clock_out,
   output wire last_stage_out,
   output reg last_stage_out_n,
   output wire shift_ready,
   output wire spill_valid,
   output wire spill_data,
   input wire spill_ready
);

   // =====================================================
   // Pin synchronisers
   // Each pin passes three flip-flops; a level change is accepted only
   // once the second and third agree, which rejects a one-sample glitch.
   reg [`SSR_SYNC_DEPTH-1:0] clk_sync_q;
   reg [`SSR_SYNC_DEPTH-1:0] a_sync_q;
   reg [`SSR_SYNC_DEPTH-1:0] b_sync_q;
   reg [`SSR_SYNC_DEPTH-1:0] sel_sync_q;
   reg clk_lvl_q;
   reg a_lvl_q;
   reg b_lvl_q;
   reg sel_lvl_q;

   function agreed;
      input [`SSR_SYNC_DEPTH-1:0] sync;
      input old_lvl;
      begin
         agreed = (sync[1] == sync[2]) ? sync[2] : old_lvl;
      end
   endfunction

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_sync_q <= 3'h0;
         clk_lvl_q <= 1'h0;
      end
      else
      begin
         clk_sync_q <= {clk_sync_q[1:0], shift_clock};
         clk_lvl_q <= agreed(clk_sync_q, clk_lvl_q);
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_sync_q <= 3'h0;
         a_lvl_q <= 1'h0;
      end
      else
      begin
         a_sync_q <= {a_sync_q[1:0], serial_in_a};
         a_lvl_q <= agreed(a_sync_q, a_lvl_q);
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         b_sync_q <= 3'h0;
         b_lvl_q <= 1'h0;
      end
      else
      begin
         b_sync_q <= {b_sync_q[1:0], serial_in_b};
         b_lvl_q <= agreed(b_sync_q, b_lvl_q);
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_sync_q <= 3'h0;
         sel_lvl_q <= 1'h0;
      end
      else
      begin
         sel_sync_q <= {sel_sync_q[1:0], select};
         sel_lvl_q <= agreed(sel_sync_q, sel_lvl_q);
      end
   end

   // =====================================================
   // Shift control
   wire clk_next;
   wire clk_rise;
   assign clk_next = agreed(clk_sync_q, clk_lvl_q);
   // Data and select are taken from their accepted levels, one cycle behind
   // the clock's, so a level that met the pin setup window is already
   // settled when the edge is accepted.
   assign clk_rise = clk_next & ~clk_lvl_q;

   // =====================================================
   // Buffered clock output
   // The copy follows the accepted level, so it lags the pin by the synchroniser.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         buffered_clock_out <= 1'h0;
      else
         buffered_clock_out <= clk_next;
   end

   // =====================================================
   // Spill buffer
   // The bit leaving the last stage on each shift is offered downstream.
   // When both entries are held and no pop happens, a shift is refused rather than losing the
   // bit; shift_ready low tells the clock source to wait.
   // The buffer never drops a bit; a refused edge is lost instead.
   reg [`SSR_BUF_DEPTH-1:0] buf_data_q;
   reg [1:0] buf_count_q;
   reg [`SSR_STAGES-1:0] chain_q;
   wire buf_full;
   wire do_shift;
   wire pop;

   assign buf_full = (buf_count_q == 2'h2);
   assign shift_ready = ~buf_full;
   assign spill_valid = (buf_count_q != 2'h0);
   assign spill_data = buf_data_q[0];
   assign pop = spill_valid & spill_ready;
   assign do_shift = clk_rise & (~buf_full | pop);

   // The count alone decides fullness, so it is kept apart from the data
   // slots and feeds the handshake outputs directly.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         buf_count_q <= 2'h0;
      else
      begin
         case ({do_shift, pop})
            2'b10:
               buf_count_q <= buf_count_q + 2'h1;
            2'b01:
               buf_count_q <= buf_count_q - 2'h1;
            default:
               buf_count_q <= buf_count_q;
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         buf_data_q <= 2'h0;
      else
      begin
         case ({do_shift, pop})
            2'b10:
               buf_data_q[buf_count_q[0]] <= chain_q[`SSR_LAST];
            2'b01:
               buf_data_q <= {1'h0, buf_data_q[1]};
            // Pop and shift together: the second entry moves up and the new
            // bit lands behind it; with one entry the new bit becomes the head.
            2'b11:
            begin
               if (buf_count_q == 2'h1)
                  buf_data_q <= {1'h0, chain_q[`SSR_LAST]};
               else
                  buf_data_q <= {chain_q[`SSR_LAST], buf_data_q[1]};
            end
            default:
               buf_data_q <= buf_data_q;
         endcase
      end
   end

   // =====================================================
   // Shift chain
   // The stages carry no reset so the chain maps onto plain storage; its
   // contents are unknown until a full 64 shifts have passed.
   wire in_bit;

   assign in_bit = (sel_lvl_q == `SSR_SEL_B) ? b_lvl_q : a_lvl_q;

   always @(posedge sys_clk)
   begin
      if (do_shift)
         chain_q <= {chain_q[`SSR_LAST-1:0], in_bit};
      else
         chain_q <= chain_q;
   end

   // =====================================================
   // Outputs from the last stage
   assign last_stage_out = chain_q[`SSR_LAST];

   // The inverse is its own flop, loaded with the bit that enters the last
   // stage, so both outputs change on the same edge.
   always @(posedge sys_clk)
   begin
      if (do_shift)
         last_stage_out_n <= ~chain_q[`SSR_LAST-1];
   end

endmodule // ssr_shift_register

// [design/ssr_regs.vh]
// Constants for the 64-stage static shift register.
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// =====================================================
// Geometry
`define SSR_STAGES 64
`define SSR_LAST 63
`define SSR_SYNC_DEPTH 3
`define SSR_BUF_DEPTH 2
// =====================================================
// Select encoding
`define SSR_SEL_A 1'h0
`define SSR_SEL_B 1'h1
`endif

// [verification/ssr_monitor.sv]
// Port checker for the shift register.
`timescale 1ns/1ps
module ssr_monitor
(
   input wire sys_clk, rst_n, shift_clock, serial_in_a, serial_in_b, select,
   input wire buffered_clock_out, last_stage_out, last_stage_out_n,
   input wire shift_ready, spill_valid, spill_data, spill_ready
);
   reg [6:0] n_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Stages hold no reset value, so the inverse check waits for 64 rises of buffered_clock_out.
   always @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         n_q <= 7'h0;
      else if ($rose(buffered_clock_out) && !n_q[6])
         n_q <= n_q + 7'h1;
   clk_rise_a: assert property ($rose(buffered_clock_out) |->
      $past(shift_clock, 3) && !$past(shift_clock, 5)) else $error("clock rise");
   clk_fall_a: assert property ($fell(buffered_clock_out) |->
      !$past(shift_clock, 3) && $past(shift_clock, 5)) else $error("clock fall");
   chain_hold_a: assert property ($changed(last_stage_out) |->
      $rose(buffered_clock_out)) else $error("chain moved");
   out_inv_a: assert property (n_q[6] |-> last_stage_out_n != last_stage_out)
      else $error("inverse");
   spill_load_a: assert property ($rose(buffered_clock_out) && shift_ready |->
      ##[0:1] spill_valid) else $error("no spill");
   spill_keep_a: assert property (spill_valid && !spill_ready |=>
      spill_valid && $stable(spill_data)) else $error("spill lost");
   spill_pop_a: assert property ($fell(spill_valid) |-> $past(spill_ready))
      else $error("spill dropped");
   buf_full_a: assert property (!shift_ready |-> spill_valid)
      else $error("full");
   cover property (n_q[6]);
   cover property (!shift_ready);
   cover property (spill_valid && spill_ready);
endmodule // ssr_monitor

// [verification/ssr_feeder.sv]
// Upstream model driving data, select and the shift clock.
`timescale 1ns/1ps
module ssr_feeder
(
   input wire sys_clk,
   input wire last_stage_out,
   input wire buffered_clock_out,
   output logic shift_clock, serial_in_a, serial_in_b, select
);
   logic hold_q = 1'h0;
   initial {shift_clock, serial_in_a, serial_in_b, select} = 4'h0;
   // The idle input carries the inverse, so a wrong pick shows at once.
   task automatic push(input logic s, input logic d);
      select <= s;
      serial_in_a <= s ? !d : d;
      serial_in_b <= s ? d : !d;
      repeat (4) @(posedge sys_clk);
      shift_clock <= 1'h1;
      repeat (4) @(posedge sys_clk);
      shift_clock <= 1'h0;
      repeat (8) @(posedge sys_clk);
   endtask
   // Chained-clock ring: the held bit keeps the right-most output until the
   // left-most register has shifted, shown by its buffered clock rising.
   task automatic recirc(output logic lost);
      int n;
      hold_q <= last_stage_out;
      @(posedge sys_clk);
      select <= 1'h1;
      serial_in_a <= !hold_q;
      serial_in_b <= hold_q;
      repeat (4) @(posedge sys_clk);
      shift_clock <= 1'h1;
      n = 0;
      while (n < 8 && buffered_clock_out !== 1'h1)
      begin
         @(posedge sys_clk);
         n++;
      end
      lost = (buffered_clock_out !== 1'h1);
      shift_clock <= 1'h0;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // ssr_feeder

// [verification/ssr_shift_register_tb.sv]
// Self-checking bench for the shift register.
`timescale 1ns/1ps
module ssr_shift_register_tb;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic spill_ready = 1'h1;
   wire shift_clock, serial_in_a, serial_in_b, select, buffered_clock_out;
   wire last_stage_out, last_stage_out_n, shift_ready, spill_valid, spill_data;
   logic [1:0] row [64];
   int n_mismatch = 0;
   int checks = 0;
   logic lost;
   always #2.5 sys_clk = ~sys_clk;
   ssr_feeder i_ssr_feeder(
      .sys_clk(sys_clk),
      .last_stage_out(last_stage_out),
      .buffered_clock_out(buffered_clock_out),
      .shift_clock(shift_clock),
      .serial_in_a(serial_in_a),
      .serial_in_b(serial_in_b),
      .select(select)
   );
   ssr_shift_register i_ssr_shift_register(
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .shift_clock(shift_clock),
      .serial_in_a(serial_in_a),
      .serial_in_b(serial_in_b),
      .select(select),
      .buffered_clock_out(buffered_clock_out),
      .last_stage_out(last_stage_out),
      .last_stage_out_n(last_stage_out_n),
      .shift_ready(shift_ready),
      .spill_valid(spill_valid),
      .spill_data(spill_data),
      .spill_ready(spill_ready)
   );
   task chk(input string name, input logic seen, input logic exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task summarize;
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 64; i++)
         row[i] = {i[1], i[0] ^ i[3] ^ i[5]};
      repeat (5) @(posedge sys_clk);
      chk("spill_valid", spill_valid, 1'h0);
      rst_n <= 1'h1;
      @(posedge sys_clk);
      for (int j = 0; j < 128; j++)
      begin
         i_ssr_feeder.push(row[j % 64][1], row[j % 64][0]);
         if (j >= 63)
            chk("last_stage_out", last_stage_out, row[(j - 63) % 64][0]);
      end
      // A full ring of 64 recirculations brings the chain back to its content.
      for (int k = 0; k < 64; k++)
      begin
         i_ssr_feeder.recirc(lost);
         if (lost)
         begin
            n_mismatch++;
            summarize();
         end
         chk("last_stage_out", last_stage_out, row[(k + 1) % 64][0]);
      end
      // Receiver stalls: two shifts fill the buffer, the third is refused.
      spill_ready <= 1'h0;
      for (int k = 1; k < 4; k++)
         i_ssr_feeder.push(1'h0, row[k][0]);
      chk("shift_ready", shift_ready, 1'h0);
      chk("last_stage_out", last_stage_out, row[2][0]);
      chk("last_stage_out_n", last_stage_out_n, !row[2][0]);
      chk("spill_data", spill_data, row[0][0]);
      spill_ready <= 1'h1;
      repeat (2) @(posedge sys_clk);
      chk("spill_data", spill_data, row[1][0]);
      summarize();
   end
endmodule // ssr_shift_register_tb
bind ssr_shift_register ssr_monitor i_ssr_monitor(.*);
